// [tesw_status.sv]
// Builds the two extended status words returned in the message buffer.
// Assumes transport strobes and host strobes are synchronous to clk.
// How it works
// - Word one is returned as the fifth message buffer word on completion or attention.
// - Data late is set when a read byte is offered while the FIFO is full.
// - Data late is also set when a write byte is requested while the FIFO is empty.
// - Bit 13 is set on a correctable data error during a read or write.
// - With the correctable flag set, a write completes in class 4 and a read in class 0.
// - Bit 8 is set on a transport read bus parity error during a read or write.
// - If the drive also saw that parity error, the hard error bit is set too.
// - Bit 1 is set whenever the drive asserts hard error during a read or write.
// - All unused bits of both words read as zero.
// - Word two is returned as the sixth message buffer word on completion or attention.
// - Bit 15 of word two shows an operation in progress with tape moving.
// - Bit 10 of word two is set when the drive stops draining the FIFO during a write.
// - Write characteristics reports the firmware revision in bits 7-0 of word two.
// - Other commands report the selected unit number in bits 2-0 of word two.
`include "tesw_defines.svh"

module tesw_status #(
  parameter logic [7:0] FW_REVISION    = 8'h01, // Arbitrary value
  parameter int         FIFO_DEPTH     = `TESW_FIFO_DEPTH,
  parameter int         CLKFAIL_CYCLES = `TESW_CLKFAIL_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Command acceptance
  input  wire logic                  cmd_accept,
  input  wire tesw_pkg::tesw_op_e    cmd_op,
  input  wire logic                  cmd_write_char,
  input  wire logic [2:0]            cmd_unit,
  // Transport side
  input  wire tesw_pkg::tesw_xport_s xport,
  input  wire logic                  tape_moving,
  input  wire logic                  op_done,
  // Controller side of the FIFO
  input  wire logic                  ctl_fifo_push,
  input  wire logic                  ctl_fifo_pop,
  output logic                       fifo_full,
  output logic                       fifo_empty,
  // Message buffer word port
  input  wire logic                  attention_event,
  input  wire logic [2:0]            msg_word_index,
  output logic [15:0]                msg_word_data,
  output logic                       msg_word_valid,
  output logic [15:0]                extended_status_word_one,
  output logic [15:0]                extended_status_word_two,
  output logic [2:0]                 completion_class,
  output logic                       report_pulse
);

  // ****************************************************
  // Command context
  // ****************************************************
  tesw_pkg::tesw_op_e op_q;
  logic               wchar_q;
  logic [2:0]         unit_q;
  wire                op_read  = (op_q == tesw_pkg::TESW_OP_READ);
  wire                op_write = (op_q == tesw_pkg::TESW_OP_WRITE);
  wire                op_rw    = op_read || op_write;

  always_ff @(posedge clk) begin
    if (srst) begin
      op_q    <= tesw_pkg::TESW_OP_IDLE;
      wchar_q <= 1'b0;
      unit_q  <= 3'h0;
    end else if (cmd_accept) begin
      op_q    <= cmd_op;
      wchar_q <= cmd_write_char;
      unit_q  <= cmd_unit;
    end
  end

  // ****************************************************
  // FIFO occupancy
  // ****************************************************
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  logic [LW-1:0] fifo_level;
  wire push = (op_read && xport.byte_offered) || (op_write && ctl_fifo_push);
  wire pop  = (op_write && xport.byte_requested) || (op_read && ctl_fifo_pop);

  tesw_fifo_level #(
    .DEPTH (FIFO_DEPTH)
  ) u_level (
    .clk   (clk),
    .srst  (srst),
    .push  (push),
    .pop   (pop),
    .full  (fifo_full),
    .empty (fifo_empty),
    .level (fifo_level)
  );

  // ****************************************************
  // Error event decode
  // ****************************************************
  wire late_rd   = op_read && xport.byte_offered && fifo_full;
  wire late_wr   = op_write && xport.byte_requested && fifo_empty;
  wire soft_ev   = op_rw && xport.soft_error;
  wire parity_ev = op_rw && xport.parity_error;
  wire hard_ev   = op_rw && (xport.hard_error
                   || (xport.parity_error && xport.parity_seen_by_drive));

  tesw_pkg::tesw_err_s err_q;
  tesw_pkg::tesw_err_s err_d;

  // New events win over the clear at command acceptance
  always_comb begin
    err_d = cmd_accept ? '0 : err_q;
    if (late_rd || late_wr) begin
      err_d.data_late_flag = 1'b1;
    end
    if (soft_ev) begin
      err_d.soft_data_error_flag = 1'b1;
    end
    if (parity_ev) begin
      err_d.transport_bus_parity_flag = 1'b1;
    end
    if (hard_ev) begin
      err_d.hard_data_error_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  // ****************************************************
  // Write clock failure watchdog
  // ****************************************************
  localparam int CW = $clog2(CLKFAIL_CYCLES + 1);
  logic [CW-1:0] stall_q;
  logic          clkfail_q;
  wire           stalled = op_write && !fifo_empty && !xport.byte_requested;
  wire           stall_hit = (stall_q == CW'(CLKFAIL_CYCLES));

  always_ff @(posedge clk) begin
    if (srst || cmd_accept || !stalled) begin
      stall_q <= '0;
    end else if (!stall_hit) begin
      stall_q <= stall_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clkfail_q <= 1'b0;
    end else if (stalled && stall_hit) begin
      clkfail_q <= 1'b1;
    end else if (cmd_accept) begin
      clkfail_q <= 1'b0;
    end
  end

  // ****************************************************
  // Word assembly
  // ****************************************************
  logic [15:0] word_one;
  logic [15:0] word_two;
  logic [7:0]  low_field;

  assign low_field = wchar_q ? FW_REVISION
                             : {5'h00, unit_q};

  always_comb begin
    word_one = `TESW_WORD_RESET;
    word_one[`TESW_W1_LATE_BIT]   = err_q.data_late_flag;
    word_one[`TESW_W1_SOFT_BIT]   = err_q.soft_data_error_flag;
    word_one[`TESW_W1_PARITY_BIT] = err_q.transport_bus_parity_flag;
    word_one[`TESW_W1_HARD_BIT]   = err_q.hard_data_error_flag;
  end

  always_comb begin
    word_two = `TESW_WORD_RESET;
    word_two[`TESW_W2_MOVING_BIT]  = tape_moving && (op_q != tesw_pkg::TESW_OP_IDLE);
    word_two[`TESW_W2_CLKFAIL_BIT] = clkfail_q;
    word_two[`TESW_W2_REV_MSB:0]   = low_field;
  end

  // ****************************************************
  // Snapshot on completion or attention
  // ****************************************************
  wire         report = op_done || attention_event;
  wire [2:0]   class_d = (op_write && err_q.soft_data_error_flag)
                         ? `TESW_CLASS_SOFT_WRITE : `TESW_CLASS_SUCCESS;
  logic [15:0] snap_one_q;
  logic [15:0] snap_two_q;
  logic [2:0]  class_q;
  logic        report_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      snap_one_q <= `TESW_WORD_RESET;
      snap_two_q <= `TESW_WORD_RESET;
      class_q    <= `TESW_CLASS_SUCCESS;
      report_q   <= 1'b0;
    end else begin
      report_q <= report;
      if (report) begin
        snap_one_q <= word_one;
        snap_two_q <= word_two;
        class_q    <= class_d;
      end
    end
  end

  assign extended_status_word_one = snap_one_q;
  assign extended_status_word_two = snap_two_q;
  assign completion_class         = class_q;
  assign report_pulse             = report_q;

  // ****************************************************
  // Message buffer word selection
  // ****************************************************
  wire sel_one = (msg_word_index == `TESW_MSG_WORD_ONE);
  wire sel_two = (msg_word_index == `TESW_MSG_WORD_TWO);

  assign msg_word_valid = sel_one || sel_two;
  assign msg_word_data  = sel_one ? snap_one_q
                        : sel_two ? snap_two_q : `TESW_WORD_RESET;

endmodule : tesw_status

// [tesw_defines.svh]
// Constants for the tape extended status word block.
// Assumes inclusion by bare name from the design files.
`ifndef TESW_DEFINES_SVH
`define TESW_DEFINES_SVH

// ****************************************************
// Message buffer word positions (zero based)
// ****************************************************
`define TESW_MSG_WORD_ONE      3'h4
`define TESW_MSG_WORD_TWO      3'h5

// ****************************************************
// Field positions of word one
// ****************************************************
`define TESW_W1_LATE_BIT       15
`define TESW_W1_SOFT_BIT       13
`define TESW_W1_PARITY_BIT     8
`define TESW_W1_HARD_BIT       1

// ****************************************************
// Field positions of word two
// ****************************************************
`define TESW_W2_MOVING_BIT     15
`define TESW_W2_CLKFAIL_BIT    10
`define TESW_W2_REV_MSB        7
`define TESW_W2_UNIT_MSB       2

// ****************************************************
// Completion classes, reset values and FIFO depth
// ****************************************************
`define TESW_CLASS_SUCCESS     3'h0
`define TESW_CLASS_SOFT_WRITE  3'h4
`define TESW_WORD_RESET        16'h0000
`define TESW_FIFO_DEPTH        16

// ****************************************************
// Write clock failure watchdog, in clock cycles
// ****************************************************
`define TESW_CLKFAIL_CYCLES    1024

`endif

// [tesw_pkg.sv]
// Types shared by the tape extended status word block.
// Assumes tesw_defines.svh is on the include path.
package tesw_pkg;

  typedef enum logic [1:0] {
    TESW_OP_IDLE  = 2'b00,
    TESW_OP_READ  = 2'b01,
    TESW_OP_WRITE = 2'b10,
    TESW_OP_OTHER = 2'b11
  } tesw_op_e;

  // Per-cycle events from the formatter bus side
  typedef struct packed {
    logic byte_offered;
    logic byte_requested;
    logic soft_error;
    logic hard_error;
    logic parity_error;
    logic parity_seen_by_drive;
  } tesw_xport_s;

  // Error flags of word one
  typedef struct packed {
    logic data_late_flag;
    logic soft_data_error_flag;
    logic transport_bus_parity_flag;
    logic hard_data_error_flag;
  } tesw_err_s;

endpackage : tesw_pkg

// [tesw_fifo_level.sv]
// Occupancy tracker of the internal transfer FIFO.
// Assumes push and pop strobes are synchronous to clk.
`include "tesw_defines.svh"

module tesw_fifo_level #(
  parameter int DEPTH = `TESW_FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       push,
  input  wire logic                       pop,
  output logic                            full,
  output logic                            empty,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int LW = $clog2(DEPTH + 1);

  logic [LW-1:0] level_q;
  logic [LW-1:0] level_d;
  wire           do_push = push && (level_q != LW'(DEPTH));
  wire           do_pop  = pop && (level_q != '0);

  assign level_d = level_q + LW'(do_push) - LW'(do_pop);
  assign full    = (level_q == LW'(DEPTH));
  assign empty   = (level_q == '0);
  assign level   = level_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

endmodule : tesw_fifo_level

// [tesw_status_properties.sv]
// Assertion checker for the extended status word block.
// Assumes it is bound to tesw_status by the statement at the foot.
module tesw_status_properties (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        op_done,
  input wire logic        attention_event,
  input wire logic        tape_moving,
  input wire logic [2:0]  msg_word_index,
  input wire logic [15:0] msg_word_data,
  input wire logic        msg_word_valid,
  input wire logic [15:0] extended_status_word_one,
  input wire logic [15:0] extended_status_word_two,
  input wire logic [2:0]  completion_class,
  input wire logic        report_pulse
);
  wire snap_req = op_done | attention_event;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_report; snap_req |=> report_pulse; endproperty
  a_report: assert property (p_report) else $error("report pulse missing");
  property p_hold;
    !snap_req |=> $stable(extended_status_word_one) && $stable(extended_status_word_two);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed without snapshot");
  property p_one;
    msg_word_index == 3'h4 |-> msg_word_valid && msg_word_data == extended_status_word_one;
  endproperty
  a_one: assert property (p_one) else $error("fifth word wrong");
  property p_two;
    msg_word_index == 3'h5 |-> msg_word_valid && msg_word_data == extended_status_word_two;
  endproperty
  a_two: assert property (p_two) else $error("sixth word wrong");
  property p_unused_one; (extended_status_word_one & 16'h5EFD) == 16'h0000; endproperty
  a_unused_one: assert property (p_unused_one) else $error("word one unused bit set");
  property p_unused_two; (extended_status_word_two & 16'h7B00) == 16'h0000; endproperty
  a_unused_two: assert property (p_unused_two) else $error("word two unused bit set");
  property p_class;
    completion_class != 3'h0 |-> completion_class == 3'h4 && extended_status_word_one[13];
  endproperty
  a_class: assert property (p_class) else $error("bad completion class");
  property p_still; snap_req && !tape_moving |=> !extended_status_word_two[15]; endproperty
  a_still: assert property (p_still) else $error("moving flag without motion");
endmodule : tesw_status_properties

bind tesw_status tesw_status_properties u_props (
  .clk(clk), .srst(srst), .op_done(op_done), .attention_event(attention_event),
  .tape_moving(tape_moving), .msg_word_index(msg_word_index),
  .msg_word_data(msg_word_data), .msg_word_valid(msg_word_valid),
  .extended_status_word_one(extended_status_word_one),
  .extended_status_word_two(extended_status_word_two),
  .completion_class(completion_class), .report_pulse(report_pulse));

// [tesw_xport_model.sv]
// Behavioural tape transport on the formatter bus side.
// Assumes the bench calls its tasks; changes land on falling edges.
module tesw_xport_model (
  input  wire logic             clk,
  output tesw_pkg::tesw_xport_s xport,
  output logic                  tape_moving
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    xport = '0;
    tape_moving = 1'b0;
  end
  // One-cycle event after a gap of idle cycles
  task automatic pulse(input logic [5:0] ev, input int gap);
    @(negedge clk);
    repeat (gap) @(negedge clk);
    xport = tesw_pkg::tesw_xport_s'(ev);
    @(negedge clk);
    xport = '0;
  endtask : pulse
  task automatic move(input logic m);
    @(negedge clk);
    tape_moving = m;
  endtask : move
endmodule : tesw_xport_model

// [tesw_status_tb.sv]
// Self-checking bench for the extended status word block.
// Assumes package, design, checker and transport model compiled first.
module tesw_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cmd_accept = 1'b0, cmd_write_char = 1'b0;
  logic op_done = 1'b0, attention_event = 1'b0, ctl_fifo_push = 1'b0, ctl_fifo_pop = 1'b0;
  logic [2:0] cmd_unit = 3'h0, msg_word_index = 3'h0, completion_class;
  tesw_pkg::tesw_op_e cmd_op = tesw_pkg::TESW_OP_IDLE;
  tesw_pkg::tesw_xport_s xport;
  logic tape_moving, fifo_full, fifo_empty, msg_word_valid, report_pulse;
  logic [15:0] msg_word_data, w1, w2;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #2 clk = ~clk;
  tesw_status #(.FW_REVISION(8'h5A), .CLKFAIL_CYCLES(8)) DUT (
    .clk(clk), .srst(srst), .cmd_accept(cmd_accept), .cmd_op(cmd_op),
    .cmd_write_char(cmd_write_char), .cmd_unit(cmd_unit), .xport(xport),
    .tape_moving(tape_moving), .op_done(op_done), .ctl_fifo_push(ctl_fifo_push),
    .ctl_fifo_pop(ctl_fifo_pop), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
    .attention_event(attention_event), .msg_word_index(msg_word_index),
    .msg_word_data(msg_word_data), .msg_word_valid(msg_word_valid),
    .extended_status_word_one(w1), .extended_status_word_two(w2),
    .completion_class(completion_class), .report_pulse(report_pulse));
  tesw_xport_model u_xport (.clk(clk), .xport(xport), .tape_moving(tape_moving));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
    @(negedge clk);
    msg_word_index = idx;
    #1;
    chk(msg_word_data, exp);
  endtask : rd
  task automatic cmd(input tesw_pkg::tesw_op_e op, input logic wc, input logic [2:0] unit);
    @(negedge clk);
    cmd_accept = 1'b1;
    cmd_op = op;
    cmd_write_char = wc;
    cmd_unit = unit;
    @(negedge clk);
    cmd_accept = 1'b0;
  endtask : cmd
  task automatic snap(input logic att);
    @(negedge clk);
    op_done = ~att;
    attention_event = att;
    @(negedge clk);
    op_done = 1'b0;
    attention_event = 1'b0;
    chk({15'h0000, report_pulse}, 16'h0001);
  endtask : snap
  task automatic t_reset;
    chk({15'h0000, fifo_empty}, 16'h0001);
    rd(3'h4, 16'h0000);
    rd(3'h5, 16'h0000);
    u_xport.move(1'b1);
    snap(1'b1);
    rd(3'h5, 16'h0000);
  endtask : t_reset
  task automatic t_late_write;
    u_xport.move(1'b1);
    cmd(tesw_pkg::TESW_OP_WRITE, 1'b0, 3'h3);
    u_xport.pulse(6'h10, 0);
    snap(1'b0);
    rd(3'h4, 16'h8000);
    rd(3'h5, 16'h8003);
  endtask : t_late_write
  task automatic t_late_read;
    cmd(tesw_pkg::TESW_OP_READ, 1'b0, 3'h6);
    for (int i = 0; i < 16; i++) u_xport.pulse(6'h20, 0);
    chk({15'h0000, fifo_full}, 16'h0001);
    u_xport.pulse(6'h20, 3);
    u_xport.pulse(6'h08, 0);
    u_xport.pulse(6'h04, 1);
    snap(1'b0);
    rd(3'h4, 16'hA002);
    chk({13'h0000, completion_class}, 16'h0000);
    rd(3'h5, 16'h8006);
    @(negedge clk) ctl_fifo_pop = 1'b1;
    repeat (16) @(negedge clk);
    ctl_fifo_pop = 1'b0;
    chk({15'h0000, fifo_empty}, 16'h0001);
  endtask : t_late_read
  task automatic t_write_errors;
    u_xport.move(1'b0);
    cmd(tesw_pkg::TESW_OP_WRITE, 1'b0, 3'h5);
    @(negedge clk) ctl_fifo_push = 1'b1;
    @(negedge clk) ctl_fifo_push = 1'b0;
    u_xport.pulse(6'h08, 0);
    u_xport.pulse(6'h02, 0);
    snap(1'b1);
    rd(3'h4, 16'h2100);
    chk({13'h0000, completion_class}, 16'h0004);
    u_xport.pulse(6'h03, 0);
    repeat (12) @(negedge clk);
    snap(1'b1);
    rd(3'h4, 16'h2102);
    rd(3'h5, 16'h0405);
    u_xport.pulse(6'h10, 0);
    chk({15'h0000, fifo_empty}, 16'h0001);
  endtask : t_write_errors
  task automatic t_write_char;
    u_xport.move(1'b1);
    cmd(tesw_pkg::TESW_OP_OTHER, 1'b1, 3'h2);
    u_xport.pulse(6'h04, 0);
    snap(1'b0);
    rd(3'h4, 16'h0000);
    rd(3'h5, 16'h805A);
  endtask : t_write_char
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_late_write();
    t_late_read();
    t_write_errors();
    t_write_char();
    final_report();
  end
endmodule : tesw_status_tb
